// ### rtl/vpic_pkg.sv
// Constants, types and helpers of the vectored priority interrupt core
// Functional notes
// - A configuration bit selects call mode or type-byte mode for every vector.
// - Call mode: raise request, then three acks return opcode and address.
// - Call mode first ack drives the call opcode and resolves priority.
// - Second and third acks give a 16-bit address spaced 4 or 8 bytes from base.
// - Four-byte spacing: bits 0-4 from level, bits 5-15 from base.
// - Eight-byte spacing: bits 0-5 from level, bits 6-15 from base.
// - Call mode second ack drives the address low byte.
// - Type mode: raise request, then exactly two acks return one vector byte.
// - Type mode first ack only resolves priority; the data bus stays undriven.
// - Type mode second ack drives five programmed bits over three level bits.
// - After reset priority is fully nested, input 0 highest, input 7 lowest.
// - Software may pick any highest input; the others follow in circular order.
// - The first ack picks the highest pending request; the last ack sets its service flag.
// - A service flag stays set until a service done command clears it.
// - With flags in service only strictly higher requests raise the request line.
// - Edge inputs re-arm only after going low; level inputs keep requesting.
// - Request latches stay frozen during the acknowledge sequence until the last ack clears the served input.
// - A non-specific service done command clears the highest service flag.
package vpic_pkg;
  localparam logic [7:0] CALL_OPCODE = 8'hcd;
  localparam logic [7:0] OFS_CONFIG = 8'h00;
  localparam logic [7:0] OFS_BASE_LO = 8'h04;
  localparam logic [7:0] OFS_BASE_HI = 8'h08;
  localparam logic [7:0] OFS_TYPE_BASE = 8'h0c;
  localparam logic [7:0] OFS_TOP_PRIO = 8'h10;
  localparam logic [7:0] OFS_MASK = 8'h14;
  localparam logic [7:0] OFS_COMMAND = 8'h18;
  localparam logic [7:0] OFS_PENDING = 8'h1c;
  localparam logic [7:0] OFS_SERVICE = 8'h20;
  localparam logic [7:0] OFS_STATUS = 8'h24;
  localparam int CMD_DONE_BIT = 0;
  localparam int TYPE_LSB = 3;
  localparam logic [2:0] RST_TOP_PRIO = 3'h0;
  localparam logic [7:0] RST_MASK = 8'h00;
  localparam logic [7:0] RST_BASE = 8'h00;
  localparam logic [4:0] RST_TYPE_BASE = 5'h00;
  localparam logic [7:0] RST_ARM = 8'hff;
  localparam logic [2:0] SPURIOUS_LEVEL = 3'h7;

  // Bit 0 type mode, bit 1 eight-byte spacing, bit 2 level triggering
  typedef struct packed {
    logic level_trig;
    logic spacing8;
    logic type_mode;
  } vpic_cfg_t;

  localparam vpic_cfg_t RST_CFG = '{level_trig: 1'b0, spacing8: 1'b0, type_mode: 1'b0};

  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_SECOND = 2'b01,
    SEQ_THIRD = 2'b10
  } vpic_seq_t;

  // Distance from the top priority input; 0 is highest
  function automatic logic [2:0] vpic_rank(input logic [2:0] lvl, input logic [2:0] top);
    return lvl - top;
  endfunction : vpic_rank

  function automatic logic [7:0] vpic_onehot(input logic [2:0] lvl);
    return 8'h01 << lvl;
  endfunction : vpic_onehot
endpackage : vpic_pkg

// ### rtl/vpic_sync.sv
// Two-stage synchroniser for the request inputs
module vpic_sync (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [7:0] async_in,
  output logic [7:0] sync_out
);
  logic [7:0] stage1;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      stage1 <= 8'h00;
      sync_out <= 8'h00;
    end else begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end
endmodule : vpic_sync

// ### rtl/vpic_prio.sv
// Rotating priority resolver over eight flags
module vpic_prio (
  input wire logic [7:0] req,
  input wire logic [2:0] top,
  output logic found,
  output logic [2:0] level,
  output logic [2:0] rank
);
  logic [2:0] idx;

  // Scan from lowest to highest so the highest set flag wins
  always_comb begin
    found = 1'b0;
    level = top;
    rank = 3'h7;
    idx = top;
    for (int r = 7; r >= 0; r--) begin
      idx = top + 3'(r);
      if (req[idx]) begin
        found = 1'b1;
        level = idx;
        rank = 3'(r);
      end
    end
  end
endmodule : vpic_prio

// ### rtl/vpic_top.sv
// Vectored priority interrupt core with acknowledge sequencer and register port
module vpic_top (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [7:0] request_input,
  input wire logic ack_pulse,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic int_req,
  output logic [7:0] ack_data,
  output logic ack_data_oe
);
  vpic_pkg::vpic_cfg_t cfg;
  vpic_pkg::vpic_seq_t state;
  logic [7:0] base_lo;
  logic [7:0] base_hi;
  logic [4:0] type_base;
  logic [2:0] top_prio;
  logic [7:0] mask;
  logic [7:0] req_sync;
  logic [7:0] arm;
  logic [7:0] pending_flags;
  logic [7:0] service_flags;
  logic [7:0] masked;
  logic p_found;
  logic [2:0] p_level;
  logic [2:0] p_rank;
  logic s_found;
  logic [2:0] s_level;
  logic [2:0] s_rank;
  logic [2:0] ack_level;
  logic ack_found;
  logic busy;
  logic first_ack;
  logic last_ack;
  logic service_done_command;
  logic next_int;
  logic [7:0] set_vec;
  logic [7:0] clr_vec;
  logic [15:0] call_addr;
  logic [7:0] type_vector;

  vpic_sync u_sync (
    .sys_clk(sys_clk),
    .srst(srst),
    .async_in(request_input),
    .sync_out(req_sync)
  );

  vpic_prio u_pend_prio (
    .req(masked),
    .top(top_prio),
    .found(p_found),
    .level(p_level),
    .rank(p_rank)
  );

  vpic_prio u_serv_prio (
    .req(service_flags),
    .top(top_prio),
    .found(s_found),
    .level(s_level),
    .rank(s_rank)
  );

  assign masked = pending_flags & ~mask;
  assign first_ack = ack_pulse && (state == vpic_pkg::SEQ_IDLE);
  // Sequence length follows the mode: two acks in type mode, three in call mode
  assign last_ack = ack_pulse && ((state == vpic_pkg::SEQ_THIRD) ||
                    ((state == vpic_pkg::SEQ_SECOND) && cfg.type_mode));
  assign busy = (state != vpic_pkg::SEQ_IDLE) || ack_pulse;
  assign service_done_command = reg_wr && (reg_addr == vpic_pkg::OFS_COMMAND) &&
                                reg_wdata[vpic_pkg::CMD_DONE_BIT];

  // Register writes
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      cfg <= vpic_pkg::RST_CFG;
      base_lo <= vpic_pkg::RST_BASE;
      base_hi <= vpic_pkg::RST_BASE;
      type_base <= vpic_pkg::RST_TYPE_BASE;
      top_prio <= vpic_pkg::RST_TOP_PRIO;
      mask <= vpic_pkg::RST_MASK;
    end else if (reg_wr) begin
      unique case (reg_addr)
        vpic_pkg::OFS_CONFIG: begin
          cfg <= vpic_pkg::vpic_cfg_t'(reg_wdata[2:0]);
        end
        vpic_pkg::OFS_BASE_LO: begin
          base_lo <= reg_wdata;
        end
        vpic_pkg::OFS_BASE_HI: begin
          base_hi <= reg_wdata;
        end
        vpic_pkg::OFS_TYPE_BASE: begin
          type_base <= reg_wdata[7:vpic_pkg::TYPE_LSB];
        end
        vpic_pkg::OFS_TOP_PRIO: begin
          top_prio <= reg_wdata[2:0];
        end
        vpic_pkg::OFS_MASK: begin
          mask <= reg_wdata;
        end
        default: begin
        end
      endcase
    end
  end

  // Request latches; edge sources that drop early are simply lost
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      arm <= vpic_pkg::RST_ARM;
      pending_flags <= 8'h00;
    end else if (last_ack) begin
      arm <= arm & ~set_vec;
      pending_flags <= pending_flags & ~set_vec;
    end else if (!busy) begin
      arm <= arm | ~req_sync;
      pending_flags <= req_sync & (cfg.level_trig ? 8'hff : arm);
    end
  end

  // Acknowledge sequencer
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state <= vpic_pkg::SEQ_IDLE;
    end else if (ack_pulse) begin
      unique case (state)
        vpic_pkg::SEQ_IDLE: begin
          state <= vpic_pkg::SEQ_SECOND;
        end
        vpic_pkg::SEQ_SECOND: begin
          state <= cfg.type_mode ? vpic_pkg::SEQ_IDLE : vpic_pkg::SEQ_THIRD;
        end
        vpic_pkg::SEQ_THIRD: begin
          state <= vpic_pkg::SEQ_IDLE;
        end
        default: begin
          state <= vpic_pkg::SEQ_IDLE;
        end
      endcase
    end
  end

  // Priority is resolved once, at the first ack, and kept for the sequence
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ack_level <= vpic_pkg::SPURIOUS_LEVEL;
      ack_found <= 1'b0;
    end else if (first_ack) begin
      ack_level <= p_found ? p_level : vpic_pkg::SPURIOUS_LEVEL;
      ack_found <= p_found;
    end
  end

  // Vector formats
  always_comb begin
    if (cfg.spacing8) begin
      call_addr = {base_hi, base_lo[7:6], ack_level, 3'h0};
    end else begin
      call_addr = {base_hi, base_lo[7:5], ack_level, 2'h0};
    end
  end

  assign type_vector = {type_base, ack_level};

  // Data bus drive, one cycle after each ack except the first ack in type mode
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ack_data <= 8'h00;
      ack_data_oe <= 1'b0;
    end else if (ack_pulse) begin
      unique case (state)
        vpic_pkg::SEQ_IDLE: begin
          ack_data <= cfg.type_mode ? 8'h00 : vpic_pkg::CALL_OPCODE;
          ack_data_oe <= !cfg.type_mode;
        end
        vpic_pkg::SEQ_SECOND: begin
          ack_data <= cfg.type_mode ? type_vector : call_addr[7:0];
          ack_data_oe <= 1'b1;
        end
        vpic_pkg::SEQ_THIRD: begin
          ack_data <= call_addr[15:8];
          ack_data_oe <= 1'b1;
        end
        default: begin
          ack_data <= 8'h00;
          ack_data_oe <= 1'b0;
        end
      endcase
    end else begin
      ack_data_oe <= 1'b0;
    end
  end

  // Service flags; a set in the same cycle as a clear wins
  always_comb begin
    set_vec = (last_ack && ack_found) ? vpic_pkg::vpic_onehot(ack_level) : 8'h00;
    clr_vec = (service_done_command && s_found) ? vpic_pkg::vpic_onehot(s_level) : 8'h00;
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      service_flags <= 8'h00;
    end else begin
      service_flags <= (service_flags & ~clr_vec) | set_vec;
    end
  end

  // Request line drops during a sequence so the host sees no second request
  assign next_int = p_found && (!s_found || (p_rank < s_rank)) && !busy;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      int_req <= 1'b0;
    end else begin
      int_req <= next_int;
    end
  end

  // Register reads, data in the cycle after the strobe
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      unique case (reg_addr)
        vpic_pkg::OFS_CONFIG: reg_rdata <= {5'h00, cfg};
        vpic_pkg::OFS_BASE_LO: reg_rdata <= base_lo;
        vpic_pkg::OFS_BASE_HI: reg_rdata <= base_hi;
        vpic_pkg::OFS_TYPE_BASE: reg_rdata <= {type_base, 3'h0};
        vpic_pkg::OFS_TOP_PRIO: reg_rdata <= {5'h00, top_prio};
        vpic_pkg::OFS_MASK: reg_rdata <= mask;
        vpic_pkg::OFS_PENDING: reg_rdata <= pending_flags;
        vpic_pkg::OFS_SERVICE: reg_rdata <= service_flags;
        vpic_pkg::OFS_STATUS: reg_rdata <= {5'h00, state, int_req};
        default: reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  chk_call_opcode: assert property (@(posedge sys_clk) disable iff (srst)
    first_ack && !cfg.type_mode |=> ack_data_oe && (ack_data == vpic_pkg::CALL_OPCODE))
    else $error("call opcode missing after first ack");

  chk_type_quiet: assert property (@(posedge sys_clk) disable iff (srst)
    first_ack && cfg.type_mode |=> !ack_data_oe)
    else $error("bus driven on first ack in type mode");

  chk_type_vector: assert property (@(posedge sys_clk) disable iff (srst)
    ack_pulse && (state == vpic_pkg::SEQ_SECOND) && cfg.type_mode
    |=> ack_data_oe && (ack_data == {$past(type_base), $past(ack_level)}))
    else $error("wrong type vector byte");

  chk_addr_low: assert property (@(posedge sys_clk) disable iff (srst)
    ack_pulse && (state == vpic_pkg::SEQ_SECOND) && !cfg.type_mode
    |=> ack_data_oe && (ack_data == $past(call_addr[7:0])))
    else $error("wrong address low byte");

  chk_addr_high: assert property (@(posedge sys_clk) disable iff (srst)
    ack_pulse && (state == vpic_pkg::SEQ_THIRD)
    |=> ack_data_oe && (ack_data == $past(base_hi)) && (state == vpic_pkg::SEQ_IDLE))
    else $error("wrong address high byte or sequence not ended");

  chk_spacing_low: assert property (@(posedge sys_clk) disable iff (srst)
    first_ack && p_found && !cfg.spacing8
    |=> (call_addr[4:0] == {$past(p_level), 2'h0}) && (call_addr[15:5] == {base_hi, base_lo[7:5]}))
    else $error("four-byte address layout wrong");

  chk_level_index: assert property (@(posedge sys_clk) disable iff (srst)
    first_ack && p_found |=> (ack_level == $past(p_level)) && masked[ack_level])
    else $error("acknowledged level is not a pending input");

  chk_latch_freeze: assert property (@(posedge sys_clk) disable iff (srst)
    (state != vpic_pkg::SEQ_IDLE) && !ack_pulse |=> $stable(pending_flags) && $stable(arm))
    else $error("request latches moved during acknowledge");

  chk_service_set: assert property (@(posedge sys_clk) disable iff (srst)
    last_ack && ack_found |=> service_flags[$past(ack_level)] && !pending_flags[$past(ack_level)])
    else $error("service flag not set at end of sequence");

  chk_nested_block: assert property (@(posedge sys_clk) disable iff (srst)
    s_found && !(p_found && (p_rank < s_rank)) |=> !int_req)
    else $error("request line raised by equal or lower priority");

  chk_done_clear: assert property (@(posedge sys_clk) disable iff (srst)
    service_done_command && s_found && !(last_ack && ack_found && (ack_level == s_level))
    |=> !service_flags[$past(s_level)])
    else $error("highest service flag not cleared");

  chk_service_hold: assert property (@(posedge sys_clk) disable iff (srst)
    !service_done_command |=> (service_flags & $past(service_flags)) == $past(service_flags))
    else $error("service flag dropped without command");
endmodule : vpic_top

// ### tb/vpic_host_model.sv
// Host model that issues acknowledge pulses and captures the vector bytes
module vpic_host_model (
  input wire logic sys_clk,
  output logic ack_pulse,
  input wire logic [7:0] ack_data,
  input wire logic ack_data_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] got [3];
  logic oe_seen [3];

  initial ack_pulse = 1'b0;

  // Gap adds idle cycles between acks so a slow host is covered too
  task automatic run(input int n, input int gap);
    for (int i = 0; i < n; i++) begin
      ack_pulse <= 1'b1;
      @(posedge sys_clk);
      ack_pulse <= 1'b0;
      @(posedge sys_clk);
      oe_seen[i] = ack_data_oe;
      got[i] = ack_data;
      repeat (gap) @(posedge sys_clk);
    end
  endtask : run
endmodule : vpic_host_model

// ### tb/vpic_top_tb.sv
// Self-checking bench for the vectored priority interrupt core
module vpic_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk, srst, ack_pulse, reg_wr, reg_rd, int_req, ack_data_oe;
  logic [7:0] request_input, reg_addr, reg_wdata, reg_rdata, ack_data;
  int fails = 0;
  int tests_run = 0;

  vpic_top dut (
    .sys_clk(sys_clk),
    .srst(srst),
    .request_input(request_input),
    .ack_pulse(ack_pulse),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .int_req(int_req),
    .ack_data(ack_data),
    .ack_data_oe(ack_data_oe)
  );

  vpic_host_model host (
    .sys_clk(sys_clk),
    .ack_pulse(ack_pulse),
    .ack_data(ack_data),
    .ack_data_oe(ack_data_oe)
  );

  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic conclude();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : conclude

  // Strobe is dropped and one idle edge passes, so calls may follow directly
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    @(posedge sys_clk);
  endtask : wr

  task automatic rd(input string name, input logic [7:0] a, input logic [7:0] exp);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(posedge sys_clk);
    check(name, reg_rdata, exp);
  endtask : rd

  task automatic wait_int();
    int n;
    n = 0;
    while (int_req !== 1'b1) begin
      @(posedge sys_clk);
      n++;
      if (n > 40) begin
        fails++;
        $display("[ERR] int_req expected 1 seen %b", int_req);
        conclude();
      end
    end
  endtask : wait_int

  task automatic quiet(input string name);
    repeat (8) @(posedge sys_clk);
    check(name, {7'h00, int_req}, 8'h00);
  endtask : quiet

  task automatic sc_reset();
    rd("config", vpic_pkg::OFS_CONFIG, 8'h00);
    rd("top", vpic_pkg::OFS_TOP_PRIO, 8'h00);
    rd("service", vpic_pkg::OFS_SERVICE, 8'h00);
    rd("unmapped", 8'hfc, 8'h00);
    check("int_idle", {7'h00, int_req}, 8'h00);
  endtask : sc_reset

  task automatic sc_call();
    wr(vpic_pkg::OFS_BASE_HI, 8'h12);
    wr(vpic_pkg::OFS_BASE_LO, 8'ha5);
    request_input <= 8'h28;
    wait_int();
    host.run(3, 0);
    check("opcode", host.got[0], vpic_pkg::CALL_OPCODE);
    check("lo4", host.got[1], 8'hac);
    check("hi4", host.got[2], 8'h12);
    check("oe3", {5'h00, host.oe_seen[0], host.oe_seen[1], host.oe_seen[2]}, 8'h07);
    rd("svc3", vpic_pkg::OFS_SERVICE, 8'h08);
    quiet("lower_held");
    wr(vpic_pkg::OFS_CONFIG, 8'h02);
    request_input <= 8'h2a;
    wait_int();
    host.run(3, 2);
    check("lo8", host.got[1], 8'h88);
    check("hi8", host.got[2], 8'h12);
    rd("svc13", vpic_pkg::OFS_SERVICE, 8'h0a);
    wr(vpic_pkg::OFS_COMMAND, 8'h01);
    rd("done1", vpic_pkg::OFS_SERVICE, 8'h08);
    quiet("still_nested");
    wr(vpic_pkg::OFS_COMMAND, 8'h01);
    rd("done3", vpic_pkg::OFS_SERVICE, 8'h00);
    request_input <= 8'h20;
    wait_int();
  endtask : sc_call

  task automatic sc_type();
    wr(vpic_pkg::OFS_CONFIG, 8'h01);
    wr(vpic_pkg::OFS_TYPE_BASE, 8'ha8);
    host.run(2, 0);
    check("oe_first", {7'h00, host.oe_seen[0]}, 8'h00);
    check("oe_second", {7'h00, host.oe_seen[1]}, 8'h01);
    check("type5", host.got[1], 8'had);
    wr(vpic_pkg::OFS_COMMAND, 8'h01);
    quiet("disarmed");
    request_input <= 8'h00;
    repeat (4) @(posedge sys_clk);
    request_input <= 8'h20;
    wait_int();
    wr(vpic_pkg::OFS_CONFIG, 8'h05);
    host.run(2, 1);
    check("level5", host.got[1], 8'had);
    wr(vpic_pkg::OFS_COMMAND, 8'h01);
    wait_int();
    request_input <= 8'h00;
    quiet("level_gone");
  endtask : sc_type

  task automatic sc_rotate();
    wr(vpic_pkg::OFS_TOP_PRIO, 8'h06);
    request_input <= 8'h84;
    wait_int();
    host.run(2, 0);
    check("rot7", host.got[1], 8'haf);
    rd("svc7", vpic_pkg::OFS_SERVICE, 8'h80);
    // Level input 7 keeps requesting, so drop it or it wins the next sequence again
    request_input <= 8'h04;
    quiet("rot_nested");
    wr(vpic_pkg::OFS_COMMAND, 8'h01);
    wait_int();
    host.run(2, 0);
    check("rot2", host.got[1], 8'haa);
    wr(vpic_pkg::OFS_COMMAND, 8'h01);
    rd("svc_end", vpic_pkg::OFS_SERVICE, 8'h00);
    wr(vpic_pkg::OFS_MASK, 8'h04);
    rd("pend_lvl", vpic_pkg::OFS_PENDING, 8'h04);
    quiet("masked");
  endtask : sc_rotate

  // Reset in mid-run must restore config, top priority, mask and the flags left by the earlier scenarios
  task automatic sc_midreset();
    request_input <= 8'h00;
    srst <= 1'b1;
    repeat (3) @(posedge sys_clk);
    srst <= 1'b0;
    @(posedge sys_clk);
    sc_reset();
    rd("mask_rst", vpic_pkg::OFS_MASK, 8'h00);
    rd("pend_rst", vpic_pkg::OFS_PENDING, 8'h00);
  endtask : sc_midreset

  initial begin
    srst = 1'b1;
    request_input = 8'h00;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    repeat (3) @(posedge sys_clk);
    srst <= 1'b0;
    @(posedge sys_clk);
    sc_reset();
    sc_call();
    sc_type();
    sc_rotate();
    sc_midreset();
    conclude();
  end
endmodule : vpic_top_tb
